// >>> shp_pkg.sv
// constants, types and register map of the shared pin parallel port
// ==========================================================================
// Summary of operation
// - peripheral outranks port in pin output muxes
// - driving peripheral disables port driver, pin readable
// - enabled idle peripheral lets port drive pin
// - port output never loops into peripheral input
// - direction one is input, zero drives latch
// - reset makes every pin an input
// - latch register reads latch, write updates latch
// - port register reads pins, write updates latch
// - invalid bits disabled, read zero everywhere
// - input-only sharing leaves port sole output source
// - analog bit one disables digital buffer, resets one
// - port B analog bits 15-12, 9-0 only
// - smallest package lacks port B analog 6,5,3
// - port C analog bits 2-0, absent on small packages
package shp_pkg;

    // ======================================================================
    // bus geometry and answers
    localparam int unsigned ADDR_W = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ======================================================================
    // register byte offsets
    localparam logic [7:0] OFS_PB_DIR = 8'h00;
    localparam logic [7:0] OFS_PB_LAT = 8'h04;
    localparam logic [7:0] OFS_PB_PORT = 8'h08;
    localparam logic [7:0] OFS_PB_ANS = 8'h0C;
    localparam logic [7:0] OFS_PC_DIR = 8'h10;
    localparam logic [7:0] OFS_PC_LAT = 8'h14;
    localparam logic [7:0] OFS_PC_PORT = 8'h18;
    localparam logic [7:0] OFS_PC_ANS = 8'h1C;

    // ======================================================================
    // reset values
    localparam logic [15:0] DIR_RST = 16'hFFFF;
    localparam logic [15:0] LAT_RST = 16'h0000;
    localparam logic [15:0] ANS_RST = 16'hFFFF;

    // ======================================================================
    // implemented bits per package variant
    localparam logic [15:0] PB_VALID_FULL = 16'hFFFF;
    localparam logic [15:0] PB_VALID_20 = 16'hFF97;
    localparam logic [15:0] PC_VALID_FULL = 16'h03FF;
    localparam logic [15:0] PC_VALID_SMALL = 16'h0000;
    localparam logic [15:0] PB_ANS_FULL = 16'hF3FF;
    localparam logic [15:0] PB_ANS_20 = 16'hF397;
    localparam logic [15:0] PC_ANS_FULL = 16'h0007;
    localparam logic [15:0] PC_ANS_SMALL = 16'h0000;

    // ======================================================================
    // types
    typedef enum logic [1:0] {
        PKG20 = 2'b00,
        PKG28 = 2'b01,
        PKG44 = 2'b10
    } shp_variant_type;

    typedef enum logic [0:0] {
        WR_IDLE = 1'b0,
        WR_RESP = 1'b1
    } shp_wstate_type;

endpackage

// >>> shp_port_top.sv
// two shared pin ports behind an axi4-lite register slave
`timescale 1ns/1ps

// ==========================================================================
// one sixteen-bit shared port
module shp_port #(
    parameter logic [15:0] VALID    = 16'hFFFF,
    parameter logic [15:0] ANS_IMPL = 16'hFFFF
) (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic        wrDir,
    input  wire logic        wrLat,
    input  wire logic        wrAns,
    input  wire logic [15:0] wrData,
    input  wire logic [15:0] wrMask,
    input  wire logic [15:0] pinIn,
    input  wire logic [15:0] periphEn,
    input  wire logic [15:0] periphDrive,
    input  wire logic [15:0] periphOut,
    input  wire logic [15:0] periphOe,
    output logic      [15:0] dirQ,
    output logic      [15:0] latQ,
    output logic      [15:0] ansQ,
    output logic      [15:0] portQ,
    output logic      [15:0] pinOut,
    output logic      [15:0] pinOe,
    output logic      [15:0] periphIn
);
    logic [15:0] dir_r, dir_nxt, lat_r, lat_nxt, ans_r, ans_nxt;
    logic [15:0] syncA_r, syncB_r, portQ_r, portQ_nxt;
    logic [15:0] pinOut_r, pinOut_nxt, pinOe_r, pinOe_nxt;
    logic [15:0] periphIn_r, periphIn_nxt, own, portDrives;

    // ======================================================================
    // ownership and next state of every register but the two synchroniser stages
    always_comb
    begin
        own = periphEn & periphDrive;
        portDrives = ~own & ~dir_r & VALID;
        dir_nxt = dir_r;
        lat_nxt = lat_r;
        ans_nxt = ans_r;
        if (wrDir)
        begin
            dir_nxt = ((dir_r & ~wrMask) | (wrData & wrMask)) & VALID;
        end
        if (wrLat)
        begin
            lat_nxt = ((lat_r & ~wrMask) | (wrData & wrMask)) & VALID;
        end
        if (wrAns)
        begin
            ans_nxt = ((ans_r & ~wrMask) | (wrData & wrMask)) & ANS_IMPL;
        end
        // analog pins and invalid bits read zero
        portQ_nxt = syncB_r & ~ans_r & VALID;
        // peripheral wins the output muxes
        pinOut_nxt = ((own & periphOut) | (~own & lat_r)) & VALID;
        pinOe_nxt = ((own & periphOe) | portDrives) & VALID;
        // no loop-through from a port-driven pin
        periphIn_nxt = syncB_r & ~ans_r & ~portDrives & VALID;
    end

    // ======================================================================
    // registers, frozen while ce is low
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            dir_r      <= shp_pkg::DIR_RST & VALID;
            lat_r      <= shp_pkg::LAT_RST;
            ans_r      <= shp_pkg::ANS_RST & ANS_IMPL;
            syncA_r    <= 16'h0000;
            syncB_r    <= 16'h0000;
            portQ_r    <= 16'h0000;
            pinOut_r   <= 16'h0000;
            pinOe_r    <= 16'h0000;
            periphIn_r <= 16'h0000;
        end
        else if (ce)
        begin
            dir_r      <= dir_nxt;
            lat_r      <= lat_nxt;
            ans_r      <= ans_nxt;
            syncA_r    <= pinIn;
            syncB_r    <= syncA_r;
            portQ_r    <= portQ_nxt;
            pinOut_r   <= pinOut_nxt;
            pinOe_r    <= pinOe_nxt;
            periphIn_r <= periphIn_nxt;
        end
    end

    assign dirQ = dir_r;
    assign latQ = lat_r;
    assign ansQ = ans_r;
    assign portQ = portQ_r;
    assign pinOut = pinOut_r;
    assign pinOe = pinOe_r;
    assign periphIn = periphIn_r;

    // ======================================================================
    // checks on the port
    dir_reset_a: assert property (
        @(posedge ref_clk) !rst_n |=> (dirQ == (shp_pkg::DIR_RST & VALID)) && (ansQ == ANS_IMPL))
        else $error("direction or analog select wrong after reset");
    periph_owns_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        ce |=> ((pinOe ^ $past(periphOe)) & $past(periphEn & periphDrive) & VALID) == 16'h0000)
        else $error("driving peripheral does not own pin enable");
    port_drives_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        ce |=> ((pinOe ^ ~$past(dirQ)) & ~$past(periphEn & periphDrive) & VALID) == 16'h0000)
        else $error("port direction not driving free pin");
    latch_out_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        ce |=> ((pinOut ^ $past(latQ)) & ~$past(dirQ | (periphEn & periphDrive))) == 16'h0000)
        else $error("output pin does not follow latch");
    no_loop_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        ce |=> (periphIn & ~$past(dirQ) & ~$past(periphEn & periphDrive)) == 16'h0000)
        else $error("port output looped into peripheral input");
    latch_write_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        ce && wrLat |=> latQ == ((($past(latQ) & ~$past(wrMask)) |
                                  ($past(wrData) & $past(wrMask))) & VALID))
        else $error("latch write lost");
    pin_sync_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (rst_n && ce) [*3] |=> portQ == ($past(pinIn, 3) & ~$past(ansQ) & VALID))
        else $error("port read not three cycles behind pin");
    invalid_zero_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        ((dirQ | latQ | portQ | pinOe) & ~VALID) == 16'h0000)
        else $error("invalid bit not zero");
    ans_impl_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (ansQ & ~ANS_IMPL) == 16'h0000)
        else $error("unimplemented analog bit set");
    analog_zero_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        ce |=> ((portQ | periphIn) & $past(ansQ)) == 16'h0000)
        else $error("analog pin read as digital one");
    periph_cov: cover property (@(posedge ref_clk) (own & periphOe) != 16'h0000);
    latch_cov: cover property (@(posedge ref_clk) ce && wrLat ##1 (pinOe != 16'h0000));
    digital_cov: cover property (@(posedge ref_clk) (ansQ == 16'h0000) && (portQ != 16'h0000));
endmodule // shp_port

// ==========================================================================
// top: axi4-lite slave plus ports b and c
module shp_port_top #(
    parameter shp_pkg::shp_variant_type VARIANT = shp_pkg::PKG44
) (
    input  wire logic                       ref_clk,
    input  wire logic                       rst_n,
    input  wire logic                       ce,
    input  wire logic [shp_pkg::ADDR_W-1:0] awaddr,
    input  wire logic                       awvalid,
    output logic                            awready,
    input  wire logic [31:0]                wdata,
    input  wire logic [3:0]                 wstrb,
    input  wire logic                       wvalid,
    output logic                            wready,
    output logic [1:0]                      bresp,
    output logic                            bvalid,
    input  wire logic                       bready,
    input  wire logic [shp_pkg::ADDR_W-1:0] araddr,
    input  wire logic                       arvalid,
    output logic                            arready,
    output logic [31:0]                     rdata,
    output logic [1:0]                      rresp,
    output logic                            rvalid,
    input  wire logic                       rready,
    input  wire logic [15:0]                pbPinIn,
    output logic [15:0]                     pbPinOut,
    output logic [15:0]                     pbPinOe,
    input  wire logic [15:0]                pbPeriphEn,
    input  wire logic [15:0]                pbPeriphDrive,
    input  wire logic [15:0]                pbPeriphOut,
    input  wire logic [15:0]                pbPeriphOe,
    output logic [15:0]                     pbPeriphIn,
    input  wire logic [15:0]                pcPinIn,
    output logic [15:0]                     pcPinOut,
    output logic [15:0]                     pcPinOe,
    input  wire logic [15:0]                pcPeriphEn,
    input  wire logic [15:0]                pcPeriphDrive,
    input  wire logic [15:0]                pcPeriphOut,
    input  wire logic [15:0]                pcPeriphOe,
    output logic [15:0]                     pcPeriphIn
);
    // implemented bits for the chosen package
    localparam logic [15:0] PB_VALID =
        (VARIANT == shp_pkg::PKG20) ? shp_pkg::PB_VALID_20 : shp_pkg::PB_VALID_FULL;
    localparam logic [15:0] PB_ANS =
        (VARIANT == shp_pkg::PKG20) ? shp_pkg::PB_ANS_20 : shp_pkg::PB_ANS_FULL;
    localparam logic [15:0] PC_VALID =
        (VARIANT == shp_pkg::PKG44) ? shp_pkg::PC_VALID_FULL : shp_pkg::PC_VALID_SMALL;
    localparam logic [15:0] PC_ANS =
        (VARIANT == shp_pkg::PKG44) ? shp_pkg::PC_ANS_FULL : shp_pkg::PC_ANS_SMALL;

    shp_pkg::shp_wstate_type wState_r, wState_nxt;
    logic                       awHave_r, awHave_nxt, wHave_r, wHave_nxt;
    logic [shp_pkg::ADDR_W-1:0] awAddr_r, awAddr_nxt;
    logic [15:0]                wData_r, wData_nxt, wMask_r, wMask_nxt;
    logic [1:0]                 bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic                       rvalid_r, rvalid_nxt;
    logic [31:0]                rdata_r, rdata_nxt;
    logic                       doWrite, wHit;
    logic                       awready_r, awready_nxt, wready_r, wready_nxt;
    logic                       bvalid_r, bvalid_nxt, arready_r, arready_nxt;
    logic [7:0]                 wSel;
    logic [15:0] pbDir, pbLat, pbAns, pbPort, pcDir, pcLat, pcAns, pcPort;

    // ======================================================================
    // write channel: address and data in either order, then response
    always_comb
    begin
        wState_nxt = wState_r;
        awHave_nxt = awHave_r;
        awAddr_nxt = awAddr_r;
        wHave_nxt = wHave_r;
        wData_nxt = wData_r;
        wMask_nxt = wMask_r;
        bresp_nxt = bresp_r;
        doWrite = 1'b0;
        wSel = 8'h00;
        wHit = 1'b1;
        case (awAddr_r)
            shp_pkg::OFS_PB_DIR:  wSel = 8'h01;
            shp_pkg::OFS_PB_LAT:  wSel = 8'h02;
            shp_pkg::OFS_PB_PORT: wSel = 8'h02;
            shp_pkg::OFS_PB_ANS:  wSel = 8'h04;
            shp_pkg::OFS_PC_DIR:  wSel = 8'h10;
            shp_pkg::OFS_PC_LAT:  wSel = 8'h20;
            shp_pkg::OFS_PC_PORT: wSel = 8'h20;
            shp_pkg::OFS_PC_ANS:  wSel = 8'h40;
            default:              wHit = 1'b0;
        endcase
        case (wState_r)
            shp_pkg::WR_IDLE:
            begin
                if (awvalid && !awHave_r)
                begin
                    awHave_nxt = 1'b1;
                    awAddr_nxt = awaddr;
                end
                if (wvalid && !wHave_r)
                begin
                    wHave_nxt = 1'b1;
                    wData_nxt = wdata[15:0];
                    wMask_nxt = {{8{wstrb[1]}}, {8{wstrb[0]}}};
                end
                if (awHave_r && wHave_r)
                begin
                    doWrite = wHit;
                    bresp_nxt = wHit ? shp_pkg::RESP_OKAY : shp_pkg::RESP_SLVERR;
                    awHave_nxt = 1'b0;
                    wHave_nxt = 1'b0;
                    wState_nxt = shp_pkg::WR_RESP;
                end
            end
            shp_pkg::WR_RESP:
            begin
                if (bready)
                begin
                    wState_nxt = shp_pkg::WR_IDLE;
                end
            end
            default: wState_nxt = shp_pkg::WR_IDLE;
        endcase
        // readies and response valid follow the next state
        awready_nxt = !awHave_nxt && (wState_nxt == shp_pkg::WR_IDLE);
        wready_nxt = !wHave_nxt && (wState_nxt == shp_pkg::WR_IDLE);
        bvalid_nxt = (wState_nxt == shp_pkg::WR_RESP);
    end

    // ======================================================================
    // read channel: one cycle from address to data
    always_comb
    begin
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (rvalid_r && rready)
        begin
            rvalid_nxt = 1'b0;
        end
        if (arvalid && !rvalid_r)
        begin
            rvalid_nxt = 1'b1;
            rresp_nxt = shp_pkg::RESP_OKAY;
            case (araddr)
                shp_pkg::OFS_PB_DIR:  rdata_nxt = {16'h0000, pbDir};
                shp_pkg::OFS_PB_LAT:  rdata_nxt = {16'h0000, pbLat};
                shp_pkg::OFS_PB_PORT: rdata_nxt = {16'h0000, pbPort};
                shp_pkg::OFS_PB_ANS:  rdata_nxt = {16'h0000, pbAns};
                shp_pkg::OFS_PC_DIR:  rdata_nxt = {16'h0000, pcDir};
                shp_pkg::OFS_PC_LAT:  rdata_nxt = {16'h0000, pcLat};
                shp_pkg::OFS_PC_PORT: rdata_nxt = {16'h0000, pcPort};
                shp_pkg::OFS_PC_ANS:  rdata_nxt = {16'h0000, pcAns};
                default:
                begin
                    rdata_nxt = 32'h0000_0000;
                    rresp_nxt = shp_pkg::RESP_SLVERR;
                end
            endcase
        end
        arready_nxt = !rvalid_nxt;
    end

    // ======================================================================
    // bus registers
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            wState_r <= shp_pkg::WR_IDLE;
            awHave_r <= 1'b0;
            awAddr_r <= 8'h00;
            wHave_r  <= 1'b0;
            wData_r  <= 16'h0000;
            wMask_r  <= 16'h0000;
            bresp_r  <= 2'h0;
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= 2'h0;
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
            bvalid_r  <= 1'b0;
            arready_r <= 1'b1;
        end
        else if (ce)
        begin
            wState_r <= wState_nxt;
            awHave_r <= awHave_nxt;
            awAddr_r <= awAddr_nxt;
            wHave_r  <= wHave_nxt;
            wData_r  <= wData_nxt;
            wMask_r  <= wMask_nxt;
            bresp_r  <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r  <= rdata_nxt;
            rresp_r  <= rresp_nxt;
            awready_r <= awready_nxt;
            wready_r  <= wready_nxt;
            bvalid_r  <= bvalid_nxt;
            arready_r <= arready_nxt;
        end
    end

    assign awready = awready_r;
    assign wready = wready_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = arready_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;

    // ======================================================================
    // the two ports
    shp_port #(.VALID(PB_VALID), .ANS_IMPL(PB_ANS)) portB (
        .ref_clk     (ref_clk),
        .rst_n       (rst_n),
        .ce          (ce),
        .wrDir       (doWrite && wSel[0]),
        .wrLat       (doWrite && wSel[1]),
        .wrAns       (doWrite && wSel[2]),
        .wrData      (wData_r),
        .wrMask      (wMask_r),
        .pinIn       (pbPinIn),
        .periphEn    (pbPeriphEn),
        .periphDrive (pbPeriphDrive),
        .periphOut   (pbPeriphOut),
        .periphOe    (pbPeriphOe),
        .dirQ        (pbDir),
        .latQ        (pbLat),
        .ansQ        (pbAns),
        .portQ       (pbPort),
        .pinOut      (pbPinOut),
        .pinOe       (pbPinOe),
        .periphIn    (pbPeriphIn)
    );

    shp_port #(.VALID(PC_VALID), .ANS_IMPL(PC_ANS)) portC (
        .ref_clk     (ref_clk),
        .rst_n       (rst_n),
        .ce          (ce),
        .wrDir       (doWrite && wSel[4]),
        .wrLat       (doWrite && wSel[5]),
        .wrAns       (doWrite && wSel[6]),
        .wrData      (wData_r),
        .wrMask      (wMask_r),
        .pinIn       (pcPinIn),
        .periphEn    (pcPeriphEn),
        .periphDrive (pcPeriphDrive),
        .periphOut   (pcPeriphOut),
        .periphOe    (pcPeriphOe),
        .dirQ        (pcDir),
        .latQ        (pcLat),
        .ansQ        (pcAns),
        .portQ       (pcPort),
        .pinOut      (pcPinOut),
        .pinOe       (pcPinOe),
        .periphIn    (pcPeriphIn)
    );

    // ======================================================================
    // bus checks
    resp_hold_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    bus_write_cov: cover property (@(posedge ref_clk) bvalid && bready && bresp == 2'h0);
endmodule // shp_port_top

// >>> shp_pin_model.sv
// outside pin model: board drivers and pull-ups facing one shared port
`timescale 1ns/1ps

// ========
// wire level seen by the port input buffers
module shp_pin_model (
    input  wire logic [15:0] pinOut,
    input  wire logic [15:0] pinOe,
    input  wire logic [15:0] extDrive,
    input  wire logic [15:0] extLevel,
    output logic      [15:0] pinLevel
);
    // port driver wins, else outside driver, else pull-up
    always_comb
    begin
        pinLevel = (pinOe & pinOut) | (~pinOe & extDrive & extLevel) | (~pinOe & ~extDrive);
    end
endmodule // shp_pin_model

// >>> tb_top.sv
// self-checking bench for the shared pin parallel port
`timescale 1ns/1ps

// ========
// bench top
module tb_top;
    logic        ref_clk, rst_n, ce, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rs;
    logic [15:0] pbPinIn, pbPinOut, pbPinOe, pbEn, pbDrv, pbOut, pbOe, pbPeriphIn;
    logic [15:0] pcPinIn, pcPinOut, pcPinOe, pcPeriphIn, extDrive, extLevel;
    int          errors, check_count;

    // design with port c peripherals idle
    shp_port_top dut_u (
        .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .pbPinIn(pbPinIn), .pbPinOut(pbPinOut), .pbPinOe(pbPinOe),
        .pbPeriphEn(pbEn), .pbPeriphDrive(pbDrv), .pbPeriphOut(pbOut),
        .pbPeriphOe(pbOe), .pbPeriphIn(pbPeriphIn),
        .pcPinIn(pcPinIn), .pcPinOut(pcPinOut), .pcPinOe(pcPinOe),
        .pcPeriphEn(16'h0000), .pcPeriphDrive(16'h0000), .pcPeriphOut(16'h0000),
        .pcPeriphOe(16'h0000), .pcPeriphIn(pcPeriphIn)
    );

    // board side of both ports
    shp_pin_model pinb_u (.pinOut(pbPinOut), .pinOe(pbPinOe), .extDrive(extDrive),
        .extLevel(extLevel), .pinLevel(pbPinIn));
    shp_pin_model pinc_u (.pinOut(pcPinOut), .pinOe(pcPinOe), .extDrive(extDrive),
        .extLevel(extLevel), .pinLevel(pcPinIn));

    // ========
    // common tasks
    task automatic test_done();
        if (errors == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tick_limit(inout int n);
        n++;
        if (n > 100)
        begin
            errors++;
            test_done();
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    // axi4-lite write, address and data offered together
    task automatic wr(input logic [7:0] a, input logic [15:0] d,
                      input logic [1:0] er = shp_pkg::RESP_OKAY);
        logic       pa = 1'b1;
        logic       pw = 1'b1;
        logic       ha, hw;
        logic       b = 1'b0;
        logic [1:0] r;
        int         n = 0;
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (pa || pw)
        begin
            @(negedge ref_clk);
            ha = awvalid && awready;
            hw = wvalid && wready;
            @(posedge ref_clk);
            awvalid <= pa && !ha;
            wvalid <= pw && !hw;
            pa = pa && !ha;
            pw = pw && !hw;
            tick_limit(n);
        end
        while (!b)
        begin
            @(negedge ref_clk);
            b = bvalid;
            r = bresp;
            @(posedge ref_clk);
            tick_limit(n);
        end
        bready <= 1'b0;
        check("bresp", {14'h0000, r}, {14'h0000, er});
    endtask

    // axi4-lite read with data and response compare
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp,
                          input logic [1:0] er = shp_pkg::RESP_OKAY);
        logic h = 1'b0;
        logic v = 1'b0;
        int   n = 0;
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!h)
        begin
            @(negedge ref_clk);
            h = arready;
            @(posedge ref_clk);
            tick_limit(n);
        end
        arvalid <= 1'b0;
        while (!v)
        begin
            @(negedge ref_clk);
            v = rvalid;
            rd = rdata;
            rs = rresp;
            @(posedge ref_clk);
            tick_limit(n);
        end
        rready <= 1'b0;
        check("rdata_hi", rd[31:16], 16'h0000);
        check("rdata", rd[15:0], exp);
        check("rresp", {14'h0000, rs}, {14'h0000, er});
    endtask

    // ========
    // scenarios
    task automatic t_reset();
        rd_chk(shp_pkg::OFS_PB_DIR, 16'hFFFF);
        rd_chk(shp_pkg::OFS_PC_DIR, 16'h03FF);
        rd_chk(shp_pkg::OFS_PB_LAT, 16'h0000);
        rd_chk(shp_pkg::OFS_PB_ANS, 16'hF3FF);
        rd_chk(shp_pkg::OFS_PC_ANS, 16'h0007);
        check("pbPinOe", pbPinOe, 16'h0000);
    endtask

    task automatic t_latch();
        wr(shp_pkg::OFS_PB_LAT, 16'hA5A5);
        rd_chk(shp_pkg::OFS_PB_LAT, 16'hA5A5);
        wr(shp_pkg::OFS_PB_PORT, 16'h5A5A);
        rd_chk(shp_pkg::OFS_PB_LAT, 16'h5A5A);
        wr(shp_pkg::OFS_PB_ANS, 16'h0000);
        wr(shp_pkg::OFS_PB_DIR, 16'h0000);
        cyc(4);
        check("pbPinOe", pbPinOe, 16'hFFFF);
        check("pbPinOut", pbPinOut, 16'h5A5A);
        check("pbPeriphIn", pbPeriphIn, 16'h0000);
        rd_chk(shp_pkg::OFS_PB_PORT, 16'h5A5A);
    endtask

    task automatic t_owner();
        @(posedge ref_clk);
        pbEn <= 16'hFFFF;
        pbDrv <= 16'h00FF;
        pbOut <= 16'h0F0F;
        pbOe <= 16'h00F0;
        cyc(4);
        check("pbPinOut", pbPinOut, 16'h5A0F);
        check("pbPinOe", pbPinOe, 16'hFFF0);
        check("pbPeriphIn", pbPeriphIn, 16'h000F);
        rd_chk(shp_pkg::OFS_PB_PORT, 16'h5A0F);
        // input-only sharing: peripheral enabled but never drives
        pbDrv <= 16'h0000;
        cyc(1);
        check("pbPinOut", pbPinOut, 16'h5A5A);
        check("pbPinOe", pbPinOe, 16'hFFFF);
    endtask

    task automatic t_input();
        wr(shp_pkg::OFS_PB_DIR, 16'hFFFF);
        pbEn <= 16'h0000;
        extDrive <= 16'hFFFF;
        extLevel <= 16'h3C3C;
        cyc(4);
        rd_chk(shp_pkg::OFS_PB_PORT, 16'h3C3C);
        check("pbPeriphIn", pbPeriphIn, 16'h3C3C);
        wr(shp_pkg::OFS_PB_ANS, 16'hF000);
        extLevel <= 16'hC3C3;
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        check("pbPeriphIn", pbPeriphIn, 16'h0C3C);
        @(negedge ref_clk);
        check("pbPeriphIn", pbPeriphIn, 16'h03C3);
        rd_chk(shp_pkg::OFS_PB_PORT, 16'h03C3);
    endtask

    task automatic t_limits();
        rd_chk(8'h40, 16'h0000, shp_pkg::RESP_SLVERR);
        wr(8'h40, 16'hFFFF, shp_pkg::RESP_SLVERR);
        wr(shp_pkg::OFS_PC_DIR, 16'hFFFF);
        rd_chk(shp_pkg::OFS_PC_DIR, 16'h03FF);
        wr(shp_pkg::OFS_PC_LAT, 16'hFFFF);
        rd_chk(shp_pkg::OFS_PC_LAT, 16'h03FF);
        wr(shp_pkg::OFS_PC_ANS, 16'hFFFF);
        rd_chk(shp_pkg::OFS_PC_ANS, 16'h0007);
        wr(shp_pkg::OFS_PB_ANS, 16'hFFFF);
        rd_chk(shp_pkg::OFS_PB_ANS, 16'hF3FF);
        rd_chk(shp_pkg::OFS_PC_PORT, 16'h03C0);
        // low clock enable freezes the synchroniser
        ce <= 1'b0;
        extLevel <= 16'h0000;
        cyc(4);
        check("pcPeriphIn", pcPeriphIn, 16'h03C0);
        check("pcPinOe", pcPinOe, 16'h0000);
        check("pcPinOut", pcPinOut, 16'h03FF);
        @(posedge ref_clk);
        ce <= 1'b1;
        cyc(3);
        check("pcPeriphIn", pcPeriphIn, 16'h0000);
        @(posedge ref_clk);
        // reset in mid-run
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd_chk(shp_pkg::OFS_PB_DIR, 16'hFFFF);
        rd_chk(shp_pkg::OFS_PB_ANS, 16'hF3FF);
    endtask

    // ========
    // clock
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // main sequence
    initial
    begin
        {rst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata, wstrb} = 52'h0;
        wstrb = 4'hF;
        ce = 1'b1;
        {pbEn, pbDrv, pbOut, pbOe, extDrive, extLevel} = 96'h0;
        errors = 0;
        check_count = 0;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset();
        t_latch();
        t_owner();
        t_input();
        t_limits();
        test_done();
    end
endmodule // tb_top
